// [rtl/asm_pkg.sv]
/*
 * Shared constants and types for the angle sensor SPI master controller:
 * command set, frame opcodes, timing figures and their cycle counts.
 * Assumes a single 250 MHz system clock; the serial clock is derived from it.
 */
package asm_pkg;

    // System clock rate
    localparam int CLK_MHZ = 250;
    localparam int TMR_W   = 28;    // Wide enough for the longest NVM wait

    // Frame layout
    localparam int FRAME_BITS = 16;
    localparam int OPC_W      = 3;
    localparam int ADDR_W     = 5;
    localparam int DATA_W     = 8;

    // Opcodes sent in the top three bits of a command frame
    localparam logic [OPC_W-1:0] OPC_READ      = 3'h2;
    localparam logic [OPC_W-1:0] OPC_WRITE     = 3'h4;
    localparam logic [OPC_W-1:0] OPC_STORE_ONE = 3'h6;
    localparam logic [OPC_W-1:0] OPC_STORE_ALL = 3'h7;
    localparam logic [OPC_W-1:0] OPC_RESTORE   = 3'h5;
    localparam logic [OPC_W-1:0] OPC_CLR_FAULT = 3'h1;

    // Timing figures in their own units
    localparam int T_IDLE_NS      = 120;  // Chip select high between transfers
    localparam int T_CSL_NS       = 120;  // Select low to first clock edge
    localparam int T_CSH_NS       = 20;   // Last rising edge to select high
    localparam int T_SCLK_HALF_NS = 20;   // Each clock level
    localparam int T_CLR_FAULT_NS = 40;
    localparam int T_RESTORE_US   = 240;
    localparam int T_STORE_ONE_MS = 23;
    localparam int T_STORE_ALL_MS = 704;

    // Least times round up to whole cycles
    localparam int C_IDLE      = (T_IDLE_NS * CLK_MHZ + 999) / 1000;
    localparam int C_CSL       = (T_CSL_NS * CLK_MHZ + 999) / 1000;
    localparam int C_CSH       = (T_CSH_NS * CLK_MHZ + 999) / 1000;
    localparam int C_SCLK_HALF = (T_SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam int C_CLR_FAULT = (T_CLR_FAULT_NS * CLK_MHZ + 999) / 1000;
    localparam int C_RESTORE   = T_RESTORE_US * CLK_MHZ;
    localparam int C_STORE_ONE = T_STORE_ONE_MS * CLK_MHZ * 1000;
    localparam int C_STORE_ALL = T_STORE_ALL_MS * CLK_MHZ * 1000;
    localparam int C_CLR_GAP   = (C_CLR_FAULT > C_IDLE) ? C_CLR_FAULT : C_IDLE;

    // Commands offered to the user side
    typedef enum logic [2:0] {
        OP_ANGLE     = 3'h0,
        OP_RD_REG    = 3'h1,
        OP_WR_REG    = 3'h2,
        OP_STORE_ONE = 3'h3,
        OP_STORE_ALL = 3'h4,
        OP_RESTORE   = 3'h5,
        OP_CLR_FAULT = 3'h6
    } asm_op_t;

    // One user request
    typedef struct packed {
        asm_op_t           op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [4:0]        nbits;   // Angle bits to clock, 0 means 16
    } asm_cmd_t;

    // One user answer
    typedef struct packed {
        logic [FRAME_BITS-1:0] word;    // Angle word, left aligned
        logic [DATA_W-1:0]     regval;  // Register value of a read
        logic [DATA_W-1:0]     angle8;  // Short angle of a read
    } asm_rsp_t;

endpackage : asm_pkg

// [rtl/asm_master.sv]
/*
 * SPI master controller for the angle sensor: turns user commands into
 * mode 0 frames of up to 16 bits, generates the serial clock by a divider, returns
 * angle and register data and waits out the sensor's busy times.
 * Assumes the sensor on the far pins and a user that keeps CMD stable
 * while CMD_VALID is high.
 */
module asm_master
    import asm_pkg::*;
#(
    parameter int SCLK_HALF                 = C_SCLK_HALF,
    parameter logic [TMR_W-1:0] STORE_ONE_CYC = TMR_W'(C_STORE_ONE),
    parameter logic [TMR_W-1:0] STORE_ALL_CYC = TMR_W'(C_STORE_ALL),
    parameter logic [TMR_W-1:0] RESTORE_CYC   = TMR_W'(C_RESTORE)
)
(
    input  wire logic     REF_CLK,
    input  wire logic     SRST,
    input  wire logic     CMD_VALID,
    output logic          CMD_READY,
    input  wire asm_cmd_t CMD,
    output logic          RSP_VALID,
    output asm_rsp_t      RSP,
    output logic          SPI_CS_N,
    output logic          SPI_SCLK,
    output logic          SPI_MOSI,
    input  wire logic     SPI_MISO
);
    import asm_pkg::*;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_LEAD = 6'h02,
        ST_LOW  = 6'h04,
        ST_HIGH = 6'h08,
        ST_TAIL = 6'h10,
        ST_GAP  = 6'h20
    } asm_state_t;

    localparam logic [TMR_W-1:0] HALF_CYC = TMR_W'(SCLK_HALF - 1);
    localparam logic [TMR_W-1:0] IDLE_CYC = TMR_W'(C_IDLE - 1);
    localparam logic [TMR_W-1:0] CSL_CYC  = TMR_W'(C_CSL - 1);
    localparam logic [TMR_W-1:0] CSH_CYC  = TMR_W'(C_CSH - 1);
    localparam logic [TMR_W-1:0] CLR_CYC  = TMR_W'(C_CLR_GAP - 1);
    localparam logic [4:0]       FULL_LEN = 5'(FRAME_BITS);

    asm_state_t            state_r;
    logic [TMR_W-1:0]      tmr_r;
    asm_cmd_t              cmd_r;
    logic                  second_r;
    logic [4:0]            len_r;
    logic [4:0]            idx_r;
    logic [FRAME_BITS-1:0] tx_r;
    logic [FRAME_BITS-1:0] rx_r;
    logic                  miso_s1_r;
    logic                  miso_s2_r;
    logic                  cs_n_r;
    logic                  sclk_r;
    logic                  mosi_r;
    logic                  ready_r;
    logic                  rsp_valid_r;
    logic                  busy_r;
    asm_rsp_t              rsp_r;

    logic                  tmr_done;
    logic                  accept;
    logic                  last_bit;
    logic                  more_frame;
    logic [4:0]            angle_len;
    logic [FRAME_BITS-1:0] frame_word;
    logic [TMR_W-1:0]      post_cyc;

    assign tmr_done   = (tmr_r == '0);
    assign accept     = (state_r == ST_IDLE) && CMD_VALID && ready_r;
    assign last_bit   = (idx_r == len_r - 5'd1);
    assign more_frame = (cmd_r.op == OP_RD_REG) && !second_r;
    // A zero length would clock nothing, so it stands for a full read
    assign angle_len  = (CMD.nbits == 5'h00 || CMD.nbits > FULL_LEN) ?
                        FULL_LEN : CMD.nbits;

    // First frame of each command; commands other than a truncated angle
    // read always go out as a full frame since short ones are discarded
    always_comb begin
        frame_word = '0;
        case (CMD.op)
            OP_RD_REG:    frame_word = {OPC_READ, CMD.addr, 8'h00};
            OP_WR_REG:    frame_word = {OPC_WRITE, CMD.addr, CMD.data};
            OP_STORE_ONE: frame_word = {OPC_STORE_ONE, CMD.addr, 8'h00};
            OP_STORE_ALL: frame_word = {OPC_STORE_ALL, 5'h00, 8'h00};
            OP_RESTORE:   frame_word = {OPC_RESTORE, 5'h00, 8'h00};
            OP_CLR_FAULT: frame_word = {OPC_CLR_FAULT, 5'h00, 8'h00};
            default:      frame_word = '0;
        endcase
    end

    // Time that select stays high after the final frame of a command
    always_comb begin
        post_cyc = IDLE_CYC;
        case (cmd_r.op)
            OP_STORE_ONE: post_cyc = STORE_ONE_CYC - 1'b1;
            OP_STORE_ALL: post_cyc = STORE_ALL_CYC - 1'b1;
            OP_RESTORE:   post_cyc = RESTORE_CYC - 1'b1;
            OP_CLR_FAULT: post_cyc = CLR_CYC;
            default:      post_cyc = IDLE_CYC;
        endcase
    end

    // MISO is asynchronous to REF_CLK; only the second stage is read
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            miso_s1_r <= 1'b0;
            miso_s2_r <= 1'b0;
        end else begin
            miso_s1_r <= SPI_MISO;
            miso_s2_r <= miso_s1_r;
        end
    end

    // Sequencer and its shared down counter
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            state_r <= ST_GAP;      // Idle time also guards the first command
            tmr_r   <= IDLE_CYC;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (accept) begin
                        state_r <= ST_LEAD;
                        tmr_r   <= CSL_CYC;
                    end
                end
                ST_LEAD: begin
                    if (tmr_done) begin
                        state_r <= ST_LOW;
                        tmr_r   <= HALF_CYC;
                    end else begin
                        tmr_r <= tmr_r - 1'b1;
                    end
                end
                ST_LOW: begin
                    if (tmr_done) begin
                        state_r <= ST_HIGH;
                        tmr_r   <= HALF_CYC;
                    end else begin
                        tmr_r <= tmr_r - 1'b1;
                    end
                end
                ST_HIGH: begin
                    if (tmr_done) begin
                        state_r <= last_bit ? ST_TAIL : ST_LOW;
                        tmr_r   <= last_bit ? CSH_CYC : HALF_CYC;
                    end else begin
                        tmr_r <= tmr_r - 1'b1;
                    end
                end
                ST_TAIL: begin
                    if (tmr_done) begin
                        state_r <= ST_GAP;
                        tmr_r   <= more_frame ? IDLE_CYC : post_cyc;
                    end else begin
                        tmr_r <= tmr_r - 1'b1;
                    end
                end
                ST_GAP: begin
                    if (!tmr_done) begin
                        tmr_r <= tmr_r - 1'b1;
                    end else if (more_frame) begin
                        state_r <= ST_LEAD;
                        tmr_r   <= CSL_CYC;
                    end else begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_GAP;
                    tmr_r   <= IDLE_CYC;
                end
            endcase
        end
    end

    // Command latch, frame selection and bit position
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            cmd_r    <= '0;
            second_r <= 1'b0;
            len_r    <= FULL_LEN;
            idx_r    <= 5'h00;
        end else begin
            if (accept) begin
                cmd_r    <= CMD;
                second_r <= 1'b0;
                len_r    <= (CMD.op == OP_ANGLE) ? angle_len : FULL_LEN;
                idx_r    <= 5'h00;
            end else if (state_r == ST_GAP && tmr_done && more_frame) begin
                second_r <= 1'b1;
                len_r    <= FULL_LEN;
                idx_r    <= 5'h00;
            end else if (state_r == ST_HIGH && tmr_done && !last_bit) begin
                idx_r <= idx_r + 5'h01;
            end
        end
    end

    // Transmit and receive shifters
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            tx_r <= '0;
            rx_r <= '0;
        end else begin
            if (accept) begin
                tx_r <= frame_word;
                rx_r <= '0;             // Unclocked low bits read as zero
            end else if (state_r == ST_GAP && tmr_done && more_frame) begin
                tx_r <= '0;             // Response frame carries no command
                rx_r <= '0;
            end else if (state_r == ST_LOW && tmr_done) begin
                tx_r <= {tx_r[FRAME_BITS-2:0], 1'b0};
            end else if (state_r == ST_HIGH && tmr_done) begin
                // Sensor shifts on falling edges, so the bit is steady here
                rx_r[4'(5'd15 - idx_r)] <= miso_s2_r;
            end
        end
    end

    // Pins: mode 0 with clock idle low, which the sensor detects itself
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            cs_n_r <= 1'b1;
            sclk_r <= 1'b0;
            mosi_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (accept) begin
                        cs_n_r <= 1'b0;
                    end
                end
                ST_LEAD: begin
                    if (tmr_done) begin
                        mosi_r <= tx_r[FRAME_BITS-1];
                    end
                end
                ST_LOW: begin
                    if (tmr_done) begin
                        sclk_r <= 1'b1;
                    end
                end
                // Data moves with the falling clock so it is settled a
                // whole half period before the sensor samples it
                ST_HIGH: begin
                    if (tmr_done) begin
                        sclk_r <= 1'b0;
                        mosi_r <= tx_r[FRAME_BITS-1];
                    end
                end
                ST_TAIL: begin
                    if (tmr_done) begin
                        cs_n_r <= 1'b1;
                        mosi_r <= 1'b0;
                    end
                end
                ST_GAP: begin
                    if (tmr_done && more_frame) begin
                        cs_n_r <= 1'b0;
                    end
                end
                default: begin
                    cs_n_r <= 1'b1;
                    sclk_r <= 1'b0;
                end
            endcase
        end
    end

    // Handshake with the user and the answer word
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            ready_r     <= 1'b0;
            rsp_valid_r <= 1'b0;
            busy_r      <= 1'b0;
            rsp_r       <= '0;
        end else begin
            rsp_valid_r <= 1'b0;
            if (accept) begin
                ready_r <= 1'b0;
                busy_r  <= 1'b1;
            end else if (state_r == ST_GAP && tmr_done && !more_frame) begin
                // The gap after reset is no command, so it gives no answer
                ready_r     <= 1'b1;
                rsp_valid_r <= busy_r;
                busy_r      <= 1'b0;
            end
            // Capture when the frame ends; a read keeps only its second frame
            if (state_r == ST_TAIL && tmr_done && !more_frame) begin
                rsp_r.word   <= rx_r;
                rsp_r.regval <= rx_r[15:8];
                rsp_r.angle8 <= rx_r[7:0];
            end
        end
    end

    assign CMD_READY = ready_r;
    assign RSP_VALID = rsp_valid_r;
    assign RSP       = rsp_r;
    assign SPI_CS_N  = cs_n_r;
    assign SPI_SCLK  = sclk_r;
    assign SPI_MOSI  = mosi_r;

endmodule // asm_master

// [tb/asm_sensor_model.sv]
/*
 * Behavioural angle sensor on the far side of the link: mode 0 slave,
 * angle buffer refreshed every microsecond while deselected, small register file.
 * Assumes clk is the 250 MHz system clock, so 250 cycles make 1 us.
 */
module asm_sensor_model #(
    parameter int REFRESH_CYC = 250,
    parameter int MISO_DLY    = 12
) (
    input  wire logic clk,
    input  wire logic cs_n,
    input  wire logic sclk,
    input  wire logic mosi,
    output logic      miso
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] buf_r = 16'h1234;
    logic [15:0] sent_r;
    logic [15:0] out_r;
    logic [15:0] rx_r;
    logic [7:0]  regs [32];
    logic [7:0]  rsp_r;
    logic        pend = 1'b0;
    int          cnt  = 0;
    int          nbit = 0;

    // Registers start at a known pattern so reads have an expected value
    initial begin
        miso = 1'b0;
        for (int i = 0; i < 32; i++) regs[i] = 8'h40 + 8'(i);
    end
    // Refresh only while deselected, so a frame never sees a torn word
    always @(posedge clk) begin
        cnt <= (cnt == REFRESH_CYC - 1) ? 0 : cnt + 1;
        if (cnt == REFRESH_CYC - 1 && cs_n) buf_r <= buf_r + 16'h0123;
    end
    // Freeze at select; a response frame puts the register byte on top
    always @(negedge cs_n) begin
        sent_r = pend ? {rsp_r, buf_r[15:8]} : buf_r;
        out_r  = sent_r;
        nbit   = 0;
        miso <= #MISO_DLY out_r[15];
    end
    // Mode 0: shift out after falling edges, slow answer within 15 ns
    always @(negedge sclk) if (!cs_n) begin
        out_r = out_r << 1;
        miso <= #MISO_DLY out_r[15];
    end
    always @(posedge sclk) if (!cs_n) begin
        rx_r = {rx_r[14:0], mosi};
        nbit++;
    end
    // Only whole frames act; the line is pulled low when deselected
    always @(posedge cs_n) begin
        pend = 1'b0;
        miso <= #MISO_DLY 1'b0;
        if (nbit == 16 && rx_r[15:13] == 3'b010 && rx_r[7:0] == 8'h00) begin
            pend  = 1'b1;
            rsp_r = regs[rx_r[12:8]];
        end
        if (nbit == 16 && rx_r[15:13] == 3'b100) regs[rx_r[12:8]] = rx_r[7:0];
    end
endmodule // asm_sensor_model

// [tb/asm_master_asserts.sv]
/*
 * Link timing and framing checks for the angle sensor controller.
 * Assumes it is bound to the controller and sees its ports only.
 */
module asm_master_asserts #(
    parameter int STORE_ONE_CYC = 50,
    parameter int STORE_ALL_CYC = 60,
    parameter int RESTORE_CYC   = 40
) (
    input wire logic              REF_CLK,
    input wire logic              SRST,
    input wire logic              CMD_VALID,
    input wire logic              CMD_READY,
    input wire asm_pkg::asm_cmd_t CMD,
    input wire logic              RSP_VALID,
    input wire asm_pkg::asm_rsp_t RSP,
    input wire logic              SPI_CS_N,
    input wire logic              SPI_SCLK,
    input wire logic              SPI_MOSI,
    input wire logic              SPI_MISO
);
    timeunit 1ns;
    timeprecision 100ps;
    import asm_pkg::*;
    int          hi_cnt;
    int          edge_cnt;
    logic        mosi_any;
    logic [15:0] rx;
    logic [2:0]  last_opc;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);

    // Cycles of select high before a fall; equal to the gap in cycles
    always_ff @(posedge REF_CLK) begin
        hi_cnt <= (SRST || !SPI_CS_N) ? 0 : hi_cnt + 1;
    end
    // Per-frame edge count and any-one flag, cleared while deselected
    always_ff @(posedge REF_CLK) begin
        if (SRST || SPI_CS_N) begin
            edge_cnt <= 0;
            mosi_any <= 1'b0;
        end else begin
            if ($rose(SPI_SCLK)) edge_cnt <= edge_cnt + 1;
            if (SPI_MOSI) mosi_any <= 1'b1;
        end
    end
    // Command of the last whole frame, to judge the wait after it
    always_ff @(posedge REF_CLK) begin
        if ($rose(SPI_SCLK)) rx <= {rx[14:0], SPI_MOSI};
        if (SRST) last_opc <= 3'h0;
        else if ($rose(SPI_CS_N)) last_opc <= (edge_cnt == 16) ? rx[15:13] : 3'h0;
    end

    a_idle_gap: assert property ($fell(SPI_CS_N) |-> hi_cnt >= C_IDLE - 1)
        else $error("select idle gap too short");
    a_mosi_steady: assert property (SPI_SCLK |-> $stable(SPI_MOSI))
        else $error("data out changed while clock high");
    a_max_edges: assert property ($rose(SPI_SCLK) |-> edge_cnt < 16)
        else $error("more than sixteen clocks in a frame");
    a_cmd_whole: assert property ($rose(SPI_CS_N) && mosi_any |-> edge_cnt == 16)
        else $error("command frame not sixteen bits");
    a_req_tail_zero: assert property ($rose(SPI_CS_N) && edge_cnt == 16 &&
        rx[15:13] == OPC_READ |-> rx[7:0] == 8'h00) else $error("request tail not zero");
    a_read_follow: assert property ($rose(SPI_CS_N) && edge_cnt == 16 &&
        rx[15:13] == OPC_READ |-> ##[29:80] $fell(SPI_CS_N)) else $error("no answer frame");
    a_store_one_wait: assert property ($fell(SPI_CS_N) && last_opc == OPC_STORE_ONE
        |-> hi_cnt >= STORE_ONE_CYC - 1) else $error("single store wait short");
    a_store_all_wait: assert property ($fell(SPI_CS_N) && last_opc == OPC_STORE_ALL
        |-> hi_cnt >= STORE_ALL_CYC - 1) else $error("full store wait short");
    a_restore_wait: assert property ($fell(SPI_CS_N) && last_opc == OPC_RESTORE
        |-> hi_cnt >= RESTORE_CYC - 1) else $error("restore wait short");
    a_clr_fault_wait: assert property ($fell(SPI_CS_N) && last_opc == OPC_CLR_FAULT
        |-> hi_cnt >= C_CLR_GAP - 1) else $error("fault clear wait short");
endmodule // asm_master_asserts

// [tb/asm_master_tb_top.sv]
/*
 * Bench for the angle sensor controller: sensor model on the link,
 * checker bound to the controller. Assumes short NVM wait parameters.
 */
module asm_master_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import asm_pkg::*;
    localparam int P_ONE = 50;
    localparam int P_ALL = 60;
    localparam int P_RST = 40;
    logic        REF_CLK   = 1'b0;
    logic        SRST      = 1'b1;
    logic        CMD_VALID = 1'b0;
    asm_cmd_t    CMD       = '0;
    logic        CMD_READY, RSP_VALID, SPI_CS_N, SPI_SCLK, SPI_MOSI, SPI_MISO;
    asm_rsp_t    RSP;
    int          failures        = 0;
    int          samples_checked = 0;
    int          dur;
    logic [15:0] w1;

    asm_master #(.STORE_ONE_CYC(TMR_W'(P_ONE)), .STORE_ALL_CYC(TMR_W'(P_ALL)),
        .RESTORE_CYC(TMR_W'(P_RST))) i_dut (.REF_CLK(REF_CLK), .SRST(SRST),
        .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD(CMD), .RSP_VALID(RSP_VALID),
        .RSP(RSP), .SPI_CS_N(SPI_CS_N), .SPI_SCLK(SPI_SCLK), .SPI_MOSI(SPI_MOSI),
        .SPI_MISO(SPI_MISO));
    asm_sensor_model #(.REFRESH_CYC(250), .MISO_DLY(12)) i_sensor (.clk(REF_CLK),
        .cs_n(SPI_CS_N), .sclk(SPI_SCLK), .mosi(SPI_MOSI), .miso(SPI_MISO));

    // 250 MHz system clock
    always #2 REF_CLK = ~REF_CLK;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One command; t ends as the cycles of select high before the answer
    task automatic run_cmd(input asm_op_t op, input logic [4:0] a, input logic [7:0] d,
                           input logic [4:0] n, output int t);
        int k;
        @(posedge REF_CLK);
        CMD_VALID <= 1'b1;
        CMD <= '{op, a, d, n};
        k = 0;
        do @(negedge REF_CLK); while (CMD_READY !== 1'b1 && ++k < 200);
        @(posedge REF_CLK);
        CMD_VALID <= 1'b0;
        t = 0;
        k = 0;
        do begin
            @(negedge REF_CLK);
            t = (SPI_CS_N === 1'b0) ? 0 : t + 1;
        end while (RSP_VALID !== 1'b1 && ++k < 3000);
        if (k >= 3000) check(16'h0000, 16'h0001);
    endtask
    // Full and truncated reads give the frozen word, upper bits first
    task automatic test_angle;
        logic [4:0]  n [5] = '{5'h01, 5'h08, 5'h0f, 5'h10, 5'h00};
        logic [15:0] m;
        foreach (n[i]) begin
            run_cmd(OP_ANGLE, 5'h00, 8'h00, n[i], dur);
            m = (n[i] == 5'h00) ? 16'hffff : ~(16'hffff >> n[i]);
            check(RSP.word, i_sensor.sent_r & m);
        end
        $display("angle readout test done");
    endtask
    // A read after more than a refresh period sees a new word
    task automatic test_refresh;
        run_cmd(OP_ANGLE, 5'h00, 8'h00, 5'h10, dur);
        w1 = RSP.word;
        repeat (300) @(posedge REF_CLK);
        run_cmd(OP_ANGLE, 5'h00, 8'h00, 5'h10, dur);
        check(16'(RSP.word != w1), 16'h0001);
        $display("refresh test done");
    endtask
    // Write then read back, and read the top address
    task automatic test_regs;
        run_cmd(OP_WR_REG, 5'h05, 8'h3c, 5'h00, dur);
        run_cmd(OP_RD_REG, 5'h05, 8'h00, 5'h00, dur);
        check(RSP.regval, 8'h3c);
        check(RSP.angle8, i_sensor.sent_r[7:0]);
        run_cmd(OP_RD_REG, 5'h1f, 8'h00, 5'h00, dur);
        check(RSP.regval, 8'h5f);
        $display("register test done");
    endtask
    // Each slow command holds select high at least its wait
    task automatic test_nvm;
        asm_op_t ops [4] = '{OP_STORE_ONE, OP_STORE_ALL, OP_RESTORE, OP_CLR_FAULT};
        int      lim [4] = '{P_ONE, P_ALL, P_RST, C_CLR_GAP};
        foreach (ops[i]) begin
            run_cmd(ops[i], 5'h03, 8'h00, 5'h00, dur);
            check(16'(dur >= lim[i]), 16'h0001);
        end
        run_cmd(OP_ANGLE, 5'h00, 8'h00, 5'h10, dur);
        $display("nvm wait test done");
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge REF_CLK);
        SRST <= 1'b0;
        test_angle;
        test_refresh;
        test_regs;
        test_nvm;
        report_and_stop;
    end
    // Watchdog: whole run needs about 4000 cycles
    initial begin
        repeat (20000) @(posedge REF_CLK);
        failures++;
        report_and_stop;
    end
endmodule // asm_master_tb_top

bind asm_master asm_master_asserts #(.STORE_ONE_CYC(STORE_ONE_CYC),
    .STORE_ALL_CYC(STORE_ALL_CYC), .RESTORE_CYC(RESTORE_CYC)) i_chk (.REF_CLK(REF_CLK),
    .SRST(SRST), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD(CMD),
    .RSP_VALID(RSP_VALID), .RSP(RSP), .SPI_CS_N(SPI_CS_N), .SPI_SCLK(SPI_SCLK),
    .SPI_MOSI(SPI_MOSI), .SPI_MISO(SPI_MISO));
